/* File: logic/foc_loop_override_regs.sv */
// Loop override, measurement control and gain readback register bank
//
// Chosen here: the Wishbone interface to the registers.
module foc_loop_override_regs
#(
	parameter int VREF_W = 11
)
(
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// Wishbone classic slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [11:0]              wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// Loop override to the control algorithm
	output logic                          inner_loop_bypass,
	output logic signed [VREF_W-1:0]      direct_axis_voltage_ref,
	output logic signed [VREF_W-1:0]      quad_axis_voltage_ref,
	// Measurement routine control
	output logic                          param_measure_start,
	output logic                          measure_resistance_en,
	output logic                          measure_inductance_en,
	output logic                          measure_backemf_const_en,
	output logic                          measure_mechanical_en,
	output logic                          store_measured_to_shadow,
	input  wire logic                     measure_busy,
	input  wire logic                     measure_done,
	// Gains in use by the current loop
	input  wire logic [foc_override_pkg::GAIN_W-1:0] inner_loop_prop_gain,
	input  wire logic [foc_override_pkg::GAIN_W-1:0] inner_loop_integral_gain
);
	import foc_override_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Gain fields must tile bits 31-12 exactly
	if (VREF_W < VCODE_W + 1 || KI_LSB + GAIN_W != KP_LSB ||
		KP_LSB + GAIN_W != 32)
	begin : g_chk
		$error("foc_loop_override_regs: unsupported widths");
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [9:0]  idx;
	logic        req;
	logic        wr_fire;
	logic        hit_ctrl;
	logic        hit_gain;
	logic        hit_stat;
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] rdata_d;
	logic        done_flag;
	logic        bad_flag;
	logic        vd_bad;
	logic        vq_bad;
	logic [VCODE_W-1:0] vd_code;
	logic [VCODE_W-1:0] vq_code;

	// New request is one not yet answered
	assign idx      = wb_adr_i[11:2];
	assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign hit_ctrl = (idx == DBG_CTRL_IDX);
	assign hit_gain = (idx == GAIN_RB_IDX);
	assign hit_stat = (idx == MEAS_STAT_IDX);
	// Writes land on the edge where the master samples the ack
	assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign vd_code  = ctrl_q[VD_LSB +: VCODE_W];
	assign vq_code  = ctrl_q[VQ_LSB +: VCODE_W];

	// ----------------------------------------------------------------
	// Acknowledge
	// ----------------------------------------------------------------
	// One wait state, every address answers, unmapped ones with zero
	always_ff @(posedge mclk)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Control word is write-only, so it reads back as zero
	always_comb
	begin
		rdata_d = '0;
		if (hit_gain)
		begin
			rdata_d[KP_LSB +: GAIN_W] = inner_loop_prop_gain;
			// Integral gain, reserved low bits zero
			rdata_d[KI_LSB +: GAIN_W] = inner_loop_integral_gain;
		end
		else if (hit_stat)
		begin
			rdata_d[STAT_BUSY_BIT] = measure_busy;
			rdata_d[STAT_DONE_BIT] = done_flag;
			rdata_d[STAT_BAD_BIT]  = bad_flag;
		end
	end

	// Captured with the ack so it stands while ack is high
	always_ff @(posedge mclk)
	begin
		if (rst)
			wb_dat_o <= GAIN_RB_RST;
		else if (req && !wb_we_i)
			wb_dat_o <= rdata_d;
	end

	// ----------------------------------------------------------------
	// Debug control word
	// ----------------------------------------------------------------
	// Byte lanes merge, then reserved and command bits are dropped
	always_comb
	begin
		ctrl_d = ctrl_q;
		for (int b = 0; b < 4; b++)
		begin
			if (wb_sel_i[b])
				ctrl_d[8*b +: 8] = wb_dat_i[8*b +: 8];
		end
		ctrl_d = ctrl_d & CTRL_KEEP_MASK;
	end

	// Held fields of the control word
	always_ff @(posedge mclk)
	begin
		if (rst)
			ctrl_q <= DBG_CTRL_RST;
		else if (wr_fire && hit_ctrl)
			ctrl_q <= ctrl_d;
	end

	assign inner_loop_bypass = ctrl_q[BYPASS_BIT];
	assign measure_resistance_en = ctrl_q[RES_BIT];
	assign measure_inductance_en = ctrl_q[IND_BIT];
	assign measure_backemf_const_en = ctrl_q[KE_BIT];
	assign measure_mechanical_en = ctrl_q[MECH_BIT];

	// ----------------------------------------------------------------
	// Command pulses
	// ----------------------------------------------------------------
	// One-cycle strobes; writing zero has no effect
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			param_measure_start      <= 1'b0;
			store_measured_to_shadow <= 1'b0;
		end
		else
		begin
			// Launch measurement on a written one
			param_measure_start <= wr_fire & hit_ctrl & wb_sel_i[0] &
				wb_dat_i[START_BIT];
			store_measured_to_shadow <= wr_fire & hit_ctrl &
				wb_sel_i[0] & wb_dat_i[SHADOW_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Forced voltage references
	// ----------------------------------------------------------------
	// Direct-axis reference from forced field
	volt_code_decode #(
		.CODE_W (VCODE_W),
		.REF_W  (VREF_W)
	) u_vd (
		.mclk  (mclk),
		.rst   (rst),
		.en    (inner_loop_bypass),
		.code  (vd_code),
		.ref_q (direct_axis_voltage_ref),
		.bad_q (vd_bad)
	);

	volt_code_decode #(
		.CODE_W (VCODE_W),
		.REF_W  (VREF_W)
	) u_vq (
		.mclk  (mclk),
		.rst   (rst),
		.en    (inner_loop_bypass),
		.code  (vq_code),
		.ref_q (quad_axis_voltage_ref),
		.bad_q (vq_bad)
	);

	// ----------------------------------------------------------------
	// Measurement status flags
	// ----------------------------------------------------------------
	// Completion of the routine, cleared by writing one
	sticky_flag u_done (
		.mclk   (mclk),
		.rst    (rst),
		.set    (measure_done),
		.clr    (wr_fire & hit_stat & wb_sel_i[0] &
			wb_dat_i[STAT_DONE_BIT]),
		.flag_q (done_flag)
	);

	// Gap code seen; re-sets while the code stays
	sticky_flag u_bad (
		.mclk   (mclk),
		.rst    (rst),
		.set    (vd_bad | vq_bad),
		.clr    (wr_fire & hit_stat & wb_sel_i[0] &
			wb_dat_i[STAT_BAD_BIT]),
		.flag_q (bad_flag)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Control word write taken on the ack edge, low lane enabled
	sequence ctrl_wr0_s;
		wr_fire && hit_ctrl && wb_sel_i[0];
	endsequence

	// Read request to the gain readback
	sequence gain_rd_s;
		req && !wb_we_i && hit_gain;
	endsequence

	// Ack is a single-cycle answer to each request
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	bypass_write_a: assert property (
		(wr_fire && hit_ctrl && wb_sel_i[3]) |=>
		inner_loop_bypass == $past(wb_dat_i[BYPASS_BIT]))
		else $error("bypass bit did not follow write");

	bypass_hold_a: assert property (
		!(wr_fire && hit_ctrl) |=> $stable(inner_loop_bypass))
		else $error("bypass bit moved without a control write");

	loops_on_zero_a: assert property (
		!inner_loop_bypass |=>
		direct_axis_voltage_ref == '0 && quad_axis_voltage_ref == '0)
		else $error("forced reference with loops enabled");

	vd_positive_a: assert property (
		(inner_loop_bypass && vd_code <= VCODE_FULL) |=>
		direct_axis_voltage_ref == VREF_W'($past(vd_code)))
		else $error("direct-axis positive code wrong");

	vd_negative_a: assert property (
		(inner_loop_bypass && vd_code >= VCODE_NEG) |=>
		direct_axis_voltage_ref ==
		VREF_W'(0) - VREF_W'($past(vd_code) - VCODE_NEG))
		else $error("direct-axis negative code wrong");

	vq_encode_a: assert property (
		(inner_loop_bypass && vq_code <= VCODE_FULL) |=>
		quad_axis_voltage_ref == VREF_W'($past(vq_code)))
		else $error("quadrature positive code wrong");

	vq_negative_a: assert property (
		(inner_loop_bypass && vq_code >= VCODE_NEG) |=>
		quad_axis_voltage_ref ==
		VREF_W'(0) - VREF_W'($past(vq_code) - VCODE_NEG))
		else $error("quadrature negative code wrong");

	gap_code_a: assert property (
		(vd_code > VCODE_FULL && vd_code < VCODE_NEG) |=>
		direct_axis_voltage_ref == '0)
		else $error("gap code not zero");

	vq_gap_a: assert property (
		(vq_code > VCODE_FULL && vq_code < VCODE_NEG) |=>
		quad_axis_voltage_ref == '0)
		else $error("quadrature gap code not zero");

	start_pulse_a: assert property (
		ctrl_wr0_s |=> param_measure_start == $past(wb_dat_i[START_BIT])
		##1 !param_measure_start)
		else $error("measurement start not a single pulse");

	res_select_a: assert property (
		ctrl_wr0_s |=>
		measure_resistance_en == $past(wb_dat_i[RES_BIT]))
		else $error("resistance select did not follow write");

	ind_select_a: assert property (
		ctrl_wr0_s |=>
		measure_inductance_en == $past(wb_dat_i[IND_BIT]))
		else $error("inductance select did not follow write");

	ke_select_a: assert property (
		ctrl_wr0_s |=>
		measure_backemf_const_en == $past(wb_dat_i[KE_BIT]))
		else $error("back-EMF select did not follow write");

	mech_select_a: assert property (
		ctrl_wr0_s |=>
		measure_mechanical_en == $past(wb_dat_i[MECH_BIT]))
		else $error("mechanical select did not follow write");

	shadow_pulse_a: assert property (
		ctrl_wr0_s |=>
		store_measured_to_shadow == $past(wb_dat_i[SHADOW_BIT])
		##1 !store_measured_to_shadow)
		else $error("shadow copy does not follow written bit");

	start_only_write_a: assert property (
		!(wr_fire && hit_ctrl) |=> !param_measure_start)
		else $error("measurement start without a control write");

	shadow_only_write_a: assert property (
		!(wr_fire && hit_ctrl) |=> !store_measured_to_shadow)
		else $error("shadow copy without a control write");

	kp_readback_a: assert property (
		gain_rd_s |=> wb_ack_o &&
		wb_dat_o[KP_LSB +: GAIN_W] == $past(inner_loop_prop_gain))
		else $error("proportional gain readback wrong");

	ki_readback_a: assert property (
		gain_rd_s |=> wb_ack_o && wb_dat_o[KI_LSB-1:0] == '0 &&
		wb_dat_o[KI_LSB +: GAIN_W] == $past(inner_loop_integral_gain))
		else $error("integral gain readback wrong");

endmodule : foc_loop_override_regs

/* File: logic/foc_override_pkg.sv */
// Register map, field layout and constants of the loop override bank
package foc_override_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0]  DBG_CTRL_IDX   = 10'h0ee;
	localparam logic [9:0]  GAIN_RB_IDX    = 10'h0f0;
	localparam logic [9:0]  MEAS_STAT_IDX  = 10'h0f4;

	// ----------------------------------------------------------------
	// Debug control word fields
	// ----------------------------------------------------------------
	localparam int          BYPASS_BIT     = 26;
	localparam int          VD_LSB         = 16;
	localparam int          VQ_LSB         = 6;
	localparam int          START_BIT      = 5;
	localparam int          RES_BIT        = 4;
	localparam int          IND_BIT        = 3;
	localparam int          KE_BIT         = 2;
	localparam int          MECH_BIT       = 1;
	localparam int          SHADOW_BIT     = 0;
	localparam int          VCODE_W        = 10;
	// Stored bits: reserved and self-clearing command bits drop out
	localparam logic [31:0] CTRL_KEEP_MASK = 32'h07ffffde;
	localparam logic [31:0] DBG_CTRL_RST   = 32'h00000000;

	// ----------------------------------------------------------------
	// Forced voltage code encoding
	// ----------------------------------------------------------------
	localparam logic [9:0]  VCODE_FULL     = 10'h1f4;
	localparam logic [9:0]  VCODE_NEG      = 10'h200;

	// ----------------------------------------------------------------
	// Gain readback and measurement status fields
	// ----------------------------------------------------------------
	localparam int          KP_LSB         = 22;
	localparam int          KI_LSB         = 12;
	localparam int          GAIN_W         = 10;
	localparam logic [31:0] GAIN_RB_RST    = 32'h00000000;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_DONE_BIT  = 1;
	localparam int          STAT_BAD_BIT   = 2;

endpackage : foc_override_pkg

/* File: logic/sticky_flag.sv */
// Sticky event flag with write-one-to-clear, set winning over clear
module sticky_flag
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Event and clear
	input  wire logic set,
	input  wire logic clr,
	// Flag
	output logic      flag_q
);

	// Set dominates so an event in the clear cycle is kept
	always_ff @(posedge mclk)
	begin
		if (rst)
			flag_q <= 1'b0;
		else
			flag_q <= set | (flag_q & ~clr);
	end

endmodule : sticky_flag

/* File: logic/volt_code_decode.sv */
// Forced voltage code to signed reference in units of 1/500
module volt_code_decode
	import foc_override_pkg::*;
#(
	parameter int CODE_W = 10,
	parameter int REF_W  = 11
)
(
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst,
	// Code in
	input  wire logic                    en,
	input  wire logic [CODE_W-1:0]       code,
	// Reference out
	output logic signed [REF_W-1:0]      ref_q,
	output logic                         bad_q
);

	// Encoding constants are fixed at ten bits
	if (CODE_W != VCODE_W || REF_W < CODE_W + 1)
	begin : g_chk
		$error("volt_code_decode: unsupported widths");
	end

	logic signed [REF_W-1:0] ref_d;
	logic                    gap;

	// Positive codes pass, codes above the base negate, gap gives zero
	always_comb
	begin
		gap = (code > VCODE_FULL) && (code < VCODE_NEG);
		if (!en || gap)
			ref_d = '0;
		else if (code <= VCODE_FULL)
			ref_d = REF_W'(code);
		else
			ref_d = REF_W'(0) - REF_W'(code - VCODE_NEG);
	end

	// Registered so the block outputs come straight from flops
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ref_q <= '0;
			bad_q <= 1'b0;
		end
		else
		begin
			ref_q <= ref_d;
			bad_q <= gap;
		end
	end

endmodule : volt_code_decode

/* File: test/tb_top.sv */
// Self-checking bench for the loop override register bank
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import foc_override_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic               mclk;
	logic               rst;
	logic               wb_cyc_i;
	logic               wb_stb_i;
	logic               wb_we_i;
	logic [11:0]        wb_adr_i;
	logic [3:0]         wb_sel_i;
	logic [31:0]        wb_dat_i;
	logic [31:0]        wb_dat_o;
	logic               wb_ack_o;
	logic               bypass;
	logic signed [10:0] vd_out;
	logic signed [10:0] vq_out;
	logic [5:0]         meas;
	logic               measure_busy;
	logic               measure_done;
	logic [9:0]         kp;
	logic [9:0]         ki;
	logic [31:0]        rdat;
	int                 n_fail;
	int                 checked;
	int                 cycles;

	localparam logic [11:0] A_CTRL = {DBG_CTRL_IDX, 2'b00};
	localparam logic [11:0] A_GAIN = {GAIN_RB_IDX, 2'b00};
	localparam logic [11:0] A_STAT = {MEAS_STAT_IDX, 2'b00};
	localparam logic [11:0] A_NONE = 12'h100;
	localparam int          LIMIT  = 20000;

	// Device under test
	foc_loop_override_regs foc_loop_override_regs_i (
		.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.inner_loop_bypass(bypass), .direct_axis_voltage_ref(vd_out),
		.quad_axis_voltage_ref(vq_out), .param_measure_start(meas[5]),
		.measure_resistance_en(meas[4]), .measure_inductance_en(meas[3]),
		.measure_backemf_const_en(meas[2]),
		.measure_mechanical_en(meas[1]),
		.store_measured_to_shadow(meas[0]), .measure_busy(measure_busy),
		.measure_done(measure_done), .inner_loop_prop_gain(kp),
		.inner_loop_integral_gain(ki));

	// Free-running clock, 8 ns period
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// Expectations and comparisons
	// ----------------------------------------------------------------
	// Gap codes read as zero so a stray write never kicks the motor
	function automatic logic signed [10:0] exp_ref(input logic [9:0] c);
		if (c <= 10'd500)
			return {1'b0, c};
		if (c >= 10'd512)
			return -$signed({1'b0, c - 10'd512});
		return 11'sd0;
	endfunction : exp_ref

	function automatic logic [31:0] ctrl(input logic b, input logic [9:0] d,
		input logic [9:0] q, input logic [5:0] low);
		return {5'h1f, b, d, q, low};
	endfunction : ctrl

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected word at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_ref(input logic [10:0] got, input logic [10:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected ref at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_ref

	task automatic chk_bits(input logic [6:0] got, input logic [6:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected flags at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_bits

	// ----------------------------------------------------------------
	// Wishbone classic master
	// ----------------------------------------------------------------
	// Holds the request until ack is seen at a rising edge
	task automatic wb(input logic we, input logic [11:0] adr,
		input logic [3:0] sel, input logic [31:0] dat);
		int n;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
			chk_bits(7'h00, 7'h01);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : wb

	task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 4'h0, 32'h00000000);
		chk_word(rdat, exp);
	endtask : rd_chk

	// Writes the control word, then checks the cycle after the ack
	task automatic wr_ctrl(input logic [3:0] sel, input logic [31:0] w,
		input logic [6:0] exp);
		wb(1'b1, A_CTRL, sel, w);
		#1;
		chk_bits({bypass, meas}, exp);
		@(posedge mclk);
		#1;
		chk_bits({bypass, meas}, exp & 7'h5e);
	endtask : wr_ctrl

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	// Hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_fail++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [9:0] cs [7];
		logic [9:0] d;
		logic [9:0] q;
		int         r;
		cs = '{10'd0, 10'd1, 10'd499, 10'd500, 10'd512, 10'd513, 10'd1000};
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{measure_busy, measure_done, kp, ki} = '0;
		{n_fail, checked, cycles} = '0;
		rst = 1'b1;
		void'($urandom(32'h6d656811));
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk_bits({bypass, meas}, 7'h00);
		chk_ref(vd_out, 11'h000);
		chk_ref(vq_out, 11'h000);
		rd_chk(A_CTRL, 32'h00000000);
		rd_chk(A_GAIN, GAIN_RB_RST);
		rd_chk(A_NONE, 32'h00000000);
		$display("test reset done");

		// Gains show live; writes to the readback are ignored
		for (int i = 0; i < 8; i++)
		begin
			@(posedge mclk);
			kp <= (i == 0) ? 10'h3ff : 10'($urandom);
			ki <= (i == 0) ? 10'h3ff : 10'($urandom);
			wb(1'b1, A_GAIN, 4'hf, 32'hffffffff);
			rd_chk(A_GAIN, {kp, ki, 12'h000});
		end
		$display("test gain done");

		// Forced references: corner codes, then random valid ones
		for (int i = 0; i < 15; i++)
		begin
			r = $urandom_range(0, 989);
			d = (i < 7) ? cs[i] : 10'((r > 500) ? r + 11 : r);
			q = (i < 7) ? cs[6 - i] : 10'($urandom_range(0, 500));
			wr_ctrl(4'hf, ctrl(1'b1, d, q, 6'h00), 7'h40);
			chk_ref(vd_out, exp_ref(d));
			chk_ref(vq_out, exp_ref(q));
		end
		wr_ctrl(4'hf, ctrl(1'b0, 10'd300, 10'd700, 6'h00), 7'h00);
		chk_ref(vd_out, 11'h000);
		chk_ref(vq_out, 11'h000);
		$display("test refs done");

		// Gap code reads as zero and raises the sticky flag
		wr_ctrl(4'hf, ctrl(1'b1, 10'd505, 10'd511, 6'h00), 7'h40);
		chk_ref(vd_out, 11'h000);
		chk_ref(vq_out, 11'h000);
		rd_chk(A_STAT, 32'h00000004);
		wr_ctrl(4'hf, ctrl(1'b1, 10'd10, 10'd20, 6'h00), 7'h40);
		wb(1'b1, A_STAT, 4'hf, 32'h00000004);
		rd_chk(A_STAT, 32'h00000000);
		$display("test gap done");

		// Each select alone, then all low bits on lane 0, then each command pulse alone
		for (int b = 1; b < 5; b++)
			wr_ctrl(4'hf, ctrl(1'b1, 10'd10, 10'd20, 6'(1 << b)),
				7'h40 | 7'(1 << b));
		wr_ctrl(4'h1, 32'h0000003f, 7'h7f);
		// Lane 3 written as zero drops the bypass; no lane 0, no pulse
		wr_ctrl(4'he, 32'h00000021, 7'h1e);
		wr_ctrl(4'hf, 32'h00000001, 7'h01);
		wr_ctrl(4'hf, 32'h00000020, 7'h20);
		$display("test measure done");

		// Busy reads live, done stays until cleared
		@(posedge mclk);
		measure_busy <= 1'b1;
		measure_done <= 1'b1;
		@(posedge mclk);
		measure_done <= 1'b0;
		rd_chk(A_STAT, 32'h00000003);
		measure_busy <= 1'b0;
		wb(1'b1, A_STAT, 4'hf, 32'h00000002);
		rd_chk(A_STAT, 32'h00000000);
		$display("test status done");
		give_verdict();
	end

endmodule : tb_top
